/* File: pfi_pkg.sv */
// Purpose: constants for the port force and edge interrupt register group
// Assumes: 32-bit register port, byte offsets as printed
// Notes: all offsets, fields, resets and timing counts live here
package pfi_pkg;
    localparam logic [11:0] OFS_PORT_FORCE = 12'h018;
    localparam logic [11:0] OFS_IRQ_SHAPE = 12'h340;
    localparam logic [11:0] OFS_DMA_START = 12'h344;
    localparam int FORCE_LSB_P1 = 0;
    localparam int FORCE_LSB_P2 = 2;
    localparam int FORCE_LSB_P3 = 4;
    localparam int FORCE_W = 2;
    localparam int NUM_PORTS = 3;
    localparam int SPACE_LSB = 24;
    localparam int SPACE_W = 8;
    localparam int PULSE_LSB = 0;
    localparam int PULSE_W = 16;
    localparam int DMA_W = 16;
    localparam logic [1:0] FORCE_NORMAL = 2'h0;
    localparam logic [1:0] FORCE_LOW = 2'h1;
    localparam logic [1:0] FORCE_FULL = 2'h2;
    localparam logic [1:0] FORCE_HIGH = 2'h3;
    localparam logic [5:0] PORT_FORCE_RST = 6'h00;
    localparam logic [7:0] SPACE_RST = 8'h00;
    localparam logic [15:0] PULSE_RST = 16'h000F;
    localparam logic [15:0] DMA_RST = 16'h0000;
    // microframe length and clock rate
    localparam int UFRAME_NS = 125000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int UFRAME_CYC = UFRAME_NS / CLK_PERIOD_NS;
endpackage : pfi_pkg

/* File: pfi_tick_if.sv */
// Purpose: carries the microframe tick between the block's modules
// Assumes: one clock domain
// Notes: tick is a one-cycle pulse
interface pfi_tick_if;
    logic tick;
    modport gen (output tick);
    modport use_tick (input tick);
endinterface : pfi_tick_if

/* File: pfi_uframe_tick.sv */
// Purpose: internal microframe tick generator
// Assumes: REF_CLK rate matches the package
// Notes: period is a parameter so benches can shorten it
module pfi_uframe_tick #(
    parameter int PERIOD = pfi_pkg::UFRAME_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    pfi_tick_if.gen tk
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } pfi_tk_st_t;
    pfi_tk_st_t s_q, s_d;
    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt >= 32'(PERIOD - 1))
        begin
            s_d.cnt = 32'h0;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.cnt = s_q.cnt + 32'h1;
        end
    end
    always_ff @(posedge clk)
    begin
        if (rst)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end
    assign tk.tick = s_q.tick;
endmodule : pfi_uframe_tick

/* File: pfi_regs.sv */
// Purpose: port speed forcing, edge interrupt shaping, dma start address
// Assumes: simple synchronous register port, writes take one cycle
// Notes: level mode passes the raw event level through one register, one clock late
//
// Summary of operation
// - three two-bit force fields at 5:4, 3:2, 1:0, reset to normal
// - field value 01 forces that port enabled at low speed
// - field value 10 forces that port enabled at full speed
// - field value 11 forces that port enabled at high speed
// - edge pulses spaced at least bits 31:24 microframes of 125 us
// - spacing zero means no gap; events during a pulse merge into one next pulse
// - spacing applies in edge mode only, not in level mode
// - edge pulse held for the clock count in bits 15:0 plus one, reset 000F
// - default count gives a sixteen-clock pulse
// - write-only dma start address at 0344, upper half reserved zero
// - low sixteen bits give the dma read/write start location
module pfi_regs #(
    parameter int UFRAME_CYCLES = pfi_pkg::UFRAME_CYC
) (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic [11:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    input wire logic IRQ_EVENT,
    input wire logic IRQ_LEVEL_MODE,
    output logic IRQ_OUT,
    output logic [2:0] PORT_FORCE_EN,
    output logic [5:0] PORT_FORCE_SPEED,
    output logic [15:0] DMA_START_ADDR
);
    typedef enum logic [1:0] {
        IDLE = 2'h0,
        PULSE = 2'h1,
        GAP = 2'h3
    } pfi_irq_st_t;

    typedef struct packed {
        logic [5:0] force_f;
        logic [7:0] space;
        logic [15:0] width;
        logic [15:0] dma;
        logic [31:0] rdata;
        pfi_irq_st_t st;
        logic [15:0] wcnt;
        logic [7:0] gcnt;
        logic pend;
        logic irq;
        logic [2:0] en;
        logic [5:0] spd;
    } pfi_state_t;

    pfi_state_t s_q, s_d;
    pfi_tick_if tk_if ();

    // shared tick keeps the gap count independent of pulse width
    pfi_uframe_tick #(
        .PERIOD(UFRAME_CYCLES)
    ) u_tick (
        .clk(REF_CLK),
        .rst(RESET),
        .ce(CE),
        .tk(tk_if.gen)
    );

    always_comb
    begin
        s_d = s_q;
        // register writes; reserved bits are simply not stored
        if (REG_WR)
        begin
            case (REG_ADDR)
                pfi_pkg::OFS_PORT_FORCE:
                    s_d.force_f = REG_WDATA[5:0];
                pfi_pkg::OFS_IRQ_SHAPE:
                begin
                    s_d.space = REG_WDATA[pfi_pkg::SPACE_LSB
                        +: pfi_pkg::SPACE_W];
                    s_d.width = REG_WDATA[pfi_pkg::PULSE_LSB
                        +: pfi_pkg::PULSE_W];
                end
                pfi_pkg::OFS_DMA_START:
                    s_d.dma = REG_WDATA[pfi_pkg::DMA_W-1:0];
                default:
                    s_d.dma = s_q.dma;
            endcase
        end
        // dma start reads zero; unmapped offsets read zero
        s_d.rdata = 32'h0;
        if (REG_RD)
        begin
            case (REG_ADDR)
                pfi_pkg::OFS_PORT_FORCE:
                    s_d.rdata = {26'h0, s_q.force_f};
                pfi_pkg::OFS_IRQ_SHAPE:
                    s_d.rdata = {s_q.space, 8'h00, s_q.width};
                default:
                    s_d.rdata = 32'h0;
            endcase
        end
        for (int p = 0; p < pfi_pkg::NUM_PORTS; p++)
        begin
            s_d.en[p] = s_q.force_f[2*p +: 2] != pfi_pkg::FORCE_NORMAL;
            s_d.spd[2*p +: 2] = s_q.force_f[2*p +: 2];
        end
        // events during pulse or gap are held in one pending bit, so several merge into one
        if (IRQ_EVENT)
            s_d.pend = 1'b1;
        if (IRQ_LEVEL_MODE)
        begin
            s_d.st = IDLE;
            s_d.pend = 1'b0;
            s_d.irq = IRQ_EVENT;
        end
        else
        begin
            case (s_q.st)
                IDLE:
                begin
                    s_d.irq = 1'b0;
                    if (s_q.pend || IRQ_EVENT)
                    begin
                        s_d.pend = 1'b0;
                        s_d.st = PULSE;
                        s_d.irq = 1'b1;
                        s_d.wcnt = s_q.width;
                    end
                end
                // high for count plus one clocks
                PULSE:
                begin
                    if (s_q.wcnt == 16'h0)
                    begin
                        s_d.irq = 1'b0;
                        s_d.gcnt = s_q.space;
                        // no gap when spacing is zero
                        s_d.st = (s_q.space == 8'h00) ? IDLE : GAP;
                    end
                    else
                        s_d.wcnt = s_q.wcnt - 16'h1;
                end
                // gap in microframe ticks
                // waits gcnt+1 ticks: the tick runs free, so the first one
                // may come a clock after the fall and must not count
                GAP:
                begin
                    s_d.irq = 1'b0;
                    if (tk_if.tick)
                    begin
                        if (s_q.gcnt == 8'h00)
                            s_d.st = IDLE;
                        else
                            s_d.gcnt = s_q.gcnt - 8'h01;
                    end
                end
                default:
                begin
                    s_d.st = IDLE;
                    s_d.irq = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            s_q <= '0;
            s_q.force_f <= pfi_pkg::PORT_FORCE_RST;
            s_q.space <= pfi_pkg::SPACE_RST;
            s_q.width <= pfi_pkg::PULSE_RST;
            s_q.dma <= pfi_pkg::DMA_RST;
            s_q.st <= IDLE;
        end
        else if (CE)
            s_q <= s_d;
    end

    assign REG_RDATA = s_q.rdata;
    assign IRQ_OUT = s_q.irq;
    assign PORT_FORCE_EN = s_q.en;
    assign PORT_FORCE_SPEED = s_q.spd;
    assign DMA_START_ADDR = s_q.dma;

    // helper: cycles since the last pulse ended
    logic [31:0] since_q;
    logic irq_d1_q;
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            since_q <= 32'hFFFFFFFF;
            irq_d1_q <= 1'b0;
        end
        else if (CE)
        begin
            irq_d1_q <= s_q.irq;
            if (irq_d1_q && !s_q.irq)
                since_q <= 32'h1;
            else if (since_q != 32'hFFFFFFFF)
                since_q <= since_q + 32'h1;
        end
    end

    // helper: spacing owed after the last fall, and the high time of the
    // current pulse against the count that was loaded when it rose
    logic [7:0] gap_ufr_q;
    logic [16:0] hi_len_q;
    logic [15:0] hi_cnt_q;
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            gap_ufr_q <= 8'h00;
            hi_len_q <= 17'h00000;
            hi_cnt_q <= 16'h0000;
        end
        else if (CE)
        begin
            if (irq_d1_q && !s_q.irq)
                gap_ufr_q <= (s_q.st == GAP) ? s_q.gcnt : 8'h00;
            if (s_q.irq)
                hi_len_q <= hi_len_q + 17'h00001;
            else
            begin
                hi_len_q <= 17'h00000;
                hi_cnt_q <= s_q.width;
            end
        end
    end

    AST_FORCE_MAP: assert property (@(posedge REF_CLK) disable iff (RESET)
        CE && !RESET |=> ##1 (!CE || PORT_FORCE_SPEED[1:0] == $past(s_q.force_f[1:0], 1)))
        else $error("port one speed does not follow its field");
    AST_FORCE_EN: assert property (@(posedge REF_CLK) disable iff (RESET)
        PORT_FORCE_EN[2] == (PORT_FORCE_SPEED[5:4] != 2'h0) || $past(!CE))
        else $error("port three enable disagrees with speed");
    AST_FORCE_HS: assert property (@(posedge REF_CLK) disable iff (RESET)
        PORT_FORCE_SPEED[3:2] == 2'h3 |-> PORT_FORCE_EN[1])
        else $error("high speed force without enable");
    AST_FORCE_RST: assert property (@(posedge REF_CLK)
        $fell(RESET) |-> s_q.force_f == pfi_pkg::PORT_FORCE_RST)
        else $error("force fields not zero after reset");
    AST_WIDTH_RST: assert property (@(posedge REF_CLK)
        $fell(RESET) |-> s_q.width == pfi_pkg::PULSE_RST)
        else $error("pulse count default wrong");
    AST_PULSE_LEN: assert property (@(posedge REF_CLK) disable iff (RESET)
        CE && !IRQ_LEVEL_MODE && s_q.st == IDLE && (s_q.pend || IRQ_EVENT)
        && s_q.width == 16'h000F ##1 (CE && !IRQ_LEVEL_MODE)[*7]
        |-> IRQ_OUT)
        else $error("edge pulse dropped early");
    AST_GAP_HOLD: assert property (@(posedge REF_CLK) disable iff (RESET)
        s_q.st == GAP |-> !IRQ_OUT)
        else $error("pulse raised inside spacing gap");
    AST_SPACING: assert property (@(posedge REF_CLK) disable iff (RESET)
        $rose(s_q.irq) && !IRQ_LEVEL_MODE && $past(s_q.st) == IDLE
        |-> since_q > 32'(UFRAME_CYCLES) * {24'h000000, gap_ufr_q})
        else $error("pulses closer than the programmed spacing");
    AST_NO_GAP: assert property (@(posedge REF_CLK) disable iff (RESET)
        CE && s_q.st == PULSE && s_q.wcnt == 16'h0 && s_q.space == 8'h00
        && !IRQ_LEVEL_MODE |=> s_q.st == IDLE)
        else $error("gap entered with zero spacing");
    AST_LEVEL: assert property (@(posedge REF_CLK) disable iff (RESET)
        CE && IRQ_LEVEL_MODE |=> IRQ_OUT == $past(IRQ_EVENT))
        else $error("level mode not passing event level");
    AST_DMA_WR: assert property (@(posedge REF_CLK) disable iff (RESET)
        CE && REG_WR && REG_ADDR == pfi_pkg::OFS_DMA_START
        |=> DMA_START_ADDR == $past(REG_WDATA[15:0]))
        else $error("dma start address not stored");
    AST_DMA_RD: assert property (@(posedge REF_CLK) disable iff (RESET)
        CE && REG_RD && REG_ADDR == pfi_pkg::OFS_DMA_START
        |=> REG_RDATA == 32'h0)
        else $error("write-only register returned data");
    AST_PULSE_W: assert property (@(posedge REF_CLK) disable iff (RESET)
        !IRQ_LEVEL_MODE && $fell(IRQ_OUT) && $past(s_q.st) == PULSE
        |-> hi_len_q == {1'b0, hi_cnt_q} + 17'h00001)
        else $error("edge pulse length differs from its count");
    // a frozen enable must not let the gap or pulse counters creep
    AST_CE_HOLD: assert property (@(posedge REF_CLK) disable iff (RESET)
        !CE |=> $stable(s_q))
        else $error("state moved while clock enable was low");
    AST_RD_ZERO: assert property (@(posedge REF_CLK) disable iff (RESET)
        CE && !REG_RD |=> REG_RDATA == 32'h0)
        else $error("read data stands after its read cycle");
    AST_RSVD_RD: assert property (@(posedge REF_CLK) disable iff (RESET)
        CE && REG_RD && REG_ADDR == pfi_pkg::OFS_PORT_FORCE
        |=> REG_RDATA == {26'h0, $past(s_q.force_f)})
        else $error("force register read back wrong");
    AST_GAP_TK: assert property (@(posedge REF_CLK) disable iff (RESET)
        CE && !IRQ_LEVEL_MODE && s_q.st == GAP && !tk_if.tick
        |=> s_q.st == GAP && $stable(s_q.gcnt))
        else $error("spacing count moved without a microframe tick");
endmodule : pfi_regs

/* File: pfi_host.sv */
// Purpose: host processor model on the register port
// Assumes: one-cycle strobes launched just after REF_CLK rises
// Notes: idle bus shows inverted values so stale data never matches
module pfi_host (
    input wire logic clk,
    output logic [11:0] addr,
    output logic wr,
    output logic rd,
    output logic [31:0] wdata,
    input wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        addr = 12'hFFF;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 32'h0;
    end
    task automatic wr32(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] m;
        m = (a == pfi_pkg::OFS_PORT_FORCE) ? 32'h0000003F :
            (a == pfi_pkg::OFS_IRQ_SHAPE) ? 32'hFF00FFFF : 32'h0000FFFF;
        @(posedge clk);
        addr <= a;
        wr <= 1'b1;
        wdata <= d & m;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~(d & m);
    endtask : wr32
    task automatic rd32(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        @(negedge clk);
        d = rdata;
    endtask : rd32
endmodule : pfi_host

/* File: pfi_regs_bench.sv */
// Purpose: self-checking bench for the register group
// Assumes: microframe shortened to 20 cycles
// Notes: pulses are measured at falling edges, away from updates
module pfi_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int UF = 20;
    logic clk, rst, ce, ev, lvl, wr, rd, irq;
    logic [11:0] addr;
    logic [31:0] wdata, rdata, d, seed;
    logic [2:0] fen;
    logic [5:0] fsp, v;
    logic [15:0] dma;
    logic [3:0] w;
    int errors, tests_run, h, g;
    always #5 clk = ~clk;
    pfi_regs #(.UFRAME_CYCLES(UF)) uut (.REF_CLK(clk), .RESET(rst),
        .CE(ce), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .IRQ_EVENT(ev),
        .IRQ_LEVEL_MODE(lvl), .IRQ_OUT(irq), .PORT_FORCE_EN(fen),
        .PORT_FORCE_SPEED(fsp), .DMA_START_ADDR(dma));
    pfi_host host (.clk(clk), .addr(addr), .wr(wr), .rd(rd),
        .wdata(wdata), .rdata(rdata));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [2:0] en_of(input logic [5:0] x);
        return {|x[5:4], |x[3:2], |x[1:0]};
    endfunction : en_of
    task automatic wrap_up;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic fire(input int n);
        @(posedge clk);
        ev <= 1'b1;
        repeat (n) @(posedge clk);
        ev <= 1'b0;
    endtask : fire
    // low cycles before the next pulse, then its high cycles
    task automatic pulse(output int hi, output int lo);
        lo = 0;
        hi = 0;
        while (irq !== 1'b1 && lo < 2000)
        begin
            @(negedge clk);
            lo++;
        end
        while (irq === 1'b1 && hi < 2000)
        begin
            @(negedge clk);
            hi++;
        end
        if (lo >= 2000 || hi >= 2000)
        begin
            errors++;
            wrap_up();
        end
    endtask : pulse
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        ev = 1'b0;
        lvl = 1'b0;
        errors = 0;
        tests_run = 0;
        seed = 32'h44AB;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        host.rd32(pfi_pkg::OFS_IRQ_SHAPE, d);
        chk(d, 32'h0000000F);
        host.rd32(pfi_pkg::OFS_PORT_FORCE, d);
        chk(d, 32'h00000000);
        // first pass sets all three force codes at once
        for (int i = 0; i < 9; i++)
        begin
            v = (i == 0) ? 6'h39 : seed[5:0];
            host.wr32(pfi_pkg::OFS_PORT_FORCE, (i == 0) ? 32'h39 : seed);
            seed = lfsr(seed);
            repeat (2) @(negedge clk);
            chk(32'(fen), 32'(en_of(v)));
            chk(32'(fsp), 32'(v));
            host.rd32(pfi_pkg::OFS_PORT_FORCE, d);
            chk(d, 32'(v));
        end
        // clock enable low: a write is ignored and nothing moves
        @(posedge clk);
        ce <= 1'b0;
        host.wr32(pfi_pkg::OFS_PORT_FORCE, ~{26'h0, v});
        @(posedge clk);
        ce <= 1'b1;
        host.rd32(pfi_pkg::OFS_PORT_FORCE, d);
        chk(d, 32'(v));
        chk(32'(fsp), 32'(v));
        host.wr32(pfi_pkg::OFS_DMA_START, seed);
        repeat (2) @(negedge clk);
        chk(32'(dma), {16'h0000, seed[15:0]});
        host.rd32(pfi_pkg::OFS_DMA_START, d);
        chk(d, 32'h00000000);
        seed = lfsr(seed);
        fork
            fire(1);
            pulse(h, g);
        join
        chk(32'(h), 32'd16);
        host.wr32(pfi_pkg::OFS_IRQ_SHAPE, 32'h00000003);
        fork
            fire(3);
            pulse(h, g);
        join
        chk(32'(h), 32'd4);
        pulse(h, g);
        chk(32'(g >= 1 && g <= 3), 32'd1);
        // random width, spacing of two microframes
        w = seed[3:0];
        host.wr32(pfi_pkg::OFS_IRQ_SHAPE, {8'h02, 8'h00, 12'h000, w});
        fork
            fire(3);
            pulse(h, g);
        join
        chk(32'(h), 32'(w) + 32'd1);
        pulse(h, g);
        chk(32'(g >= 2 * UF && g <= 3 * UF + 3), 32'd1);
        @(posedge clk);
        lvl <= 1'b1;
        fork
            fire(5);
            pulse(h, g);
        join
        chk(32'(h), 32'd5);
        fork
            fire(2);
            pulse(h, g);
        join
        chk(32'(h == 2 && g <= 3), 32'd1);
        wrap_up();
    end
endmodule : pfi_regs_bench
